//--- acs_pkg.sv
// Shared constants, types and register map of the conversion sequencer
package acs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned MCLK_MHZ = 250;
  localparam int unsigned MIN_PERIOD_NS = 10000;
  localparam int unsigned MIN_PERIOD_CYC = (MIN_PERIOD_NS * MCLK_MHZ) / 1000;
  localparam logic [11:0] GAP_LOAD = 12'(MIN_PERIOD_CYC - 1);
  localparam logic [1:0] TRACK_LAST = 2'h2;
  localparam logic [3:0] CONV_CLKS_DEF = 4'hB;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_CONFIG = 4'h1;
  localparam logic [3:0] OFS_RES_HIGH = 4'h2;
  localparam logic [3:0] OFS_RES_LOW = 4'h3;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ_CLEAR = 4'h5;
  localparam logic [3:0] OFS_IRQ_ENABLE = 4'h6;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'hF8;
  localparam int unsigned CTRL_BUSY_BIT = 4;
  localparam int unsigned CONFIG_DIV_LSB = 3;
  localparam int unsigned DIV_W = 5;

  localparam int unsigned STAT_W = 2;
  localparam int unsigned STAT_DONE_BIT = 0;
  localparam int unsigned STAT_OVERRUN_BIT = 1;

  localparam int unsigned RES_W = 10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SM_SOFTWARE = 2'h0,
    SM_TIMER3 = 2'h1,
    SM_EXT_PIN = 2'h2,
    SM_TIMER2 = 2'h3
  } acs_start_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_TRACK = 3'h2,
    ST_CONV = 3'h4
  } acs_state_t;

  typedef struct packed {
    logic converter_enable;
    logic track_mode;
    logic conv_done_flag;
    logic conv_busy;
    acs_start_mode_t start_mode;
    logic window_match_flag;
    logic left_justify;
  } acs_ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } acs_req_t;

endpackage : acs_pkg

//--- acs_clk_div.sv
// Conversion clock divider producing one-cycle ticks
`timescale 1ns/100ps
module acs_clk_div #(
  parameter int unsigned DIV_W = 5
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Divider setting and tick
  input wire logic [DIV_W-1:0] div,
  output logic tick
);

  logic [DIV_W-1:0] cnt;

  // ----------------------------------------------------------------
  // Divide by div plus one
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (cnt == '0) begin
      cnt <= div;
      tick <= 1'b1;
    end else begin
      cnt <= cnt - 1'b1;
      tick <= 1'b0;
    end
  end

endmodule : acs_clk_div

//--- acs_ext_sync.sv
// Synchroniser and rising edge detector for the external start pin
`timescale 1ns/100ps
module acs_ext_sync (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Pin in, clean level and edge out
  input wire logic pin,
  output logic level,
  output logic rise
);

  logic s1;
  logic s2;
  logic s3;

  // ----------------------------------------------------------------
  // Three stage chain
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // ----------------------------------------------------------------
  // Level changes once stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      level <= 1'b0;
      rise <= 1'b0;
    end else begin
      if (s2 == s3) begin
        level <= s3;
      end
      rise <= (s2 == s3) && s3 && !level;
    end
  end

  chk_rise_agreed: assert property (@(posedge mclk) disable iff (reset)
    rise |-> level && $past(s3) && $past(s2))
    else $error("pin edge reported without agreement");

endmodule : acs_ext_sync

//--- acs_sequencer.sv
// Conversion sequencer: start select, tracking, busy, result, registers
`timescale 1ns/100ps
module acs_sequencer #(
  parameter logic [3:0] CONV_CLKS = acs_pkg::CONV_CLKS_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire acs_pkg::acs_req_t req,
  output logic [7:0] rdata,
  // Start sources and standby
  input wire logic timer3_ovf,
  input wire logic timer2_ovf,
  input wire logic ext_conv_start,
  input wire logic chip_standby,
  // Analog core
  input wire logic [acs_pkg::RES_W-1:0] ana_result,
  output logic analog_power,
  output logic track_en,
  output logic hold_convert,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  acs_pkg::acs_ctrl_t ctrl;
  acs_pkg::acs_ctrl_t wctrl;
  acs_pkg::acs_state_t state;
  acs_pkg::acs_state_t next_state;
  logic [7:0] config_reg;
  logic [acs_pkg::RES_W-1:0] result;
  logic [acs_pkg::STAT_W-1:0] status;
  logic [acs_pkg::STAT_W-1:0] irq_en;
  logic [1:0] track_cnt;
  logic [3:0] conv_cnt;
  logic [11:0] gap_cnt;
  logic sar_tick;
  logic ext_level;
  logic ext_rise;
  logic busy;
  logic ctrl_wr;
  logic sw_start;
  logic start_evt;
  logic accept;
  logic overrun;
  logic conv_end;
  logic lp_ext;
  logic [15:0] just_word;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] justify(
    input logic [acs_pkg::RES_W-1:0] r,
    input logic left
  );
    logic [15:0] w;
    w = 16'h0000;
    if (left) begin
      w[15:6] = r;
    end else begin
      w[9:0] = r;
    end
    return w;
  endfunction : justify

  function automatic logic is_addr(
    input logic [acs_pkg::ADDR_W-1:0] a,
    input logic [acs_pkg::ADDR_W-1:0] ofs
  );
    return a == ofs;
  endfunction : is_addr

  // ----------------------------------------------------------------
  // Sub blocks
  // ----------------------------------------------------------------
  acs_clk_div #(
    .DIV_W(acs_pkg::DIV_W)
  ) u_div (
    .mclk(mclk),
    .reset(reset),
    .div(config_reg[acs_pkg::CONFIG_DIV_LSB +: acs_pkg::DIV_W]),
    .tick(sar_tick)
  );

  acs_ext_sync u_sync (
    .mclk(mclk),
    .reset(reset),
    .pin(ext_conv_start),
    .level(ext_level),
    .rise(ext_rise)
  );

  // ----------------------------------------------------------------
  // Start selection
  // ----------------------------------------------------------------
  assign wctrl = acs_pkg::acs_ctrl_t'(req.wdata);
  assign ctrl_wr = req.wr && is_addr(req.addr, acs_pkg::OFS_CTRL);
  assign sw_start = ctrl_wr && wctrl.conv_busy;
  assign busy = state != acs_pkg::ST_IDLE;
  assign lp_ext = ctrl.track_mode && (ctrl.start_mode == acs_pkg::SM_EXT_PIN);

  always_comb begin
    case (ctrl.start_mode)
      acs_pkg::SM_SOFTWARE: start_evt = sw_start;
      acs_pkg::SM_TIMER3: start_evt = timer3_ovf;
      acs_pkg::SM_EXT_PIN: start_evt = ext_rise;
      acs_pkg::SM_TIMER2: start_evt = timer2_ovf;
      default: start_evt = 1'b0;
    endcase
  end

  assign accept = start_evt && ctrl.converter_enable && !busy
    && (gap_cnt == 12'h000);
  assign overrun = start_evt && ctrl.converter_enable && !accept;

  // ----------------------------------------------------------------
  // Throughput gate
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      gap_cnt <= 12'h000;
    end else if (accept) begin
      gap_cnt <= acs_pkg::GAP_LOAD;
    end else if (gap_cnt != 12'h000) begin
      gap_cnt <= gap_cnt - 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // Sequence state machine
  // ----------------------------------------------------------------
  assign conv_end = (state == acs_pkg::ST_CONV) && sar_tick
    && (conv_cnt == CONV_CLKS - 4'h1) && ctrl.converter_enable;

  always_comb begin
    next_state = state;
    case (state)
      acs_pkg::ST_IDLE: begin
        if (accept) begin
          if (ctrl.track_mode && !lp_ext) begin
            next_state = acs_pkg::ST_TRACK;
          end else begin
            next_state = acs_pkg::ST_CONV;
          end
        end
      end
      acs_pkg::ST_TRACK: begin
        if (sar_tick && track_cnt == acs_pkg::TRACK_LAST) begin
          next_state = acs_pkg::ST_CONV;
        end
      end
      acs_pkg::ST_CONV: begin
        if (conv_end) begin
          next_state = acs_pkg::ST_IDLE;
        end
      end
      default: next_state = acs_pkg::ST_IDLE;
    endcase
    if (!ctrl.converter_enable) begin
      next_state = acs_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= acs_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      track_cnt <= 2'h0;
    end else if (state != acs_pkg::ST_TRACK) begin
      track_cnt <= 2'h0;
    end else if (sar_tick) begin
      track_cnt <= track_cnt + 2'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      conv_cnt <= 4'h0;
    end else if (state != acs_pkg::ST_CONV) begin
      conv_cnt <= 4'h0;
    end else if (sar_tick) begin
      conv_cnt <= conv_cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Analog core controls
  // ----------------------------------------------------------------
  always_comb begin
    track_en = 1'b0;
    if (ctrl.converter_enable && !chip_standby) begin
      if (state == acs_pkg::ST_TRACK) begin
        track_en = 1'b1;
      end else if (state == acs_pkg::ST_IDLE) begin
        if (!ctrl.track_mode) begin
          track_en = 1'b1;
        end else if (lp_ext) begin
          track_en = !ext_level;
        end
      end
    end
  end

  assign analog_power = ctrl.converter_enable;
  assign hold_convert = state == acs_pkg::ST_CONV;

  // ----------------------------------------------------------------
  // Control and configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl <= acs_pkg::acs_ctrl_t'(acs_pkg::CTRL_RESET);
    end else begin
      if (ctrl_wr) begin
        ctrl <= wctrl;
      end
      ctrl.conv_busy <= 1'b0;
      if (conv_end) begin
        ctrl.conv_done_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      config_reg <= acs_pkg::CONFIG_RESET;
    end else if (req.wr && is_addr(req.addr, acs_pkg::OFS_CONFIG)) begin
      config_reg <= req.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      result <= '0;
    end else if (conv_end) begin
      result <= ana_result;
    end
  end

  assign just_word = justify(result, ctrl.left_justify);

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      status <= '0;
    end else begin
      if (req.wr && is_addr(req.addr, acs_pkg::OFS_IRQ_CLEAR)) begin
        status <= status & ~req.wdata[acs_pkg::STAT_W-1:0];
      end
      if (conv_end) begin
        status[acs_pkg::STAT_DONE_BIT] <= 1'b1;
      end
      if (overrun) begin
        status[acs_pkg::STAT_OVERRUN_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_en <= '0;
    end else if (req.wr && is_addr(req.addr, acs_pkg::OFS_IRQ_ENABLE)) begin
      irq_en <= req.wdata[acs_pkg::STAT_W-1:0];
    end
  end

  assign irq = |(status & irq_en);

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        acs_pkg::OFS_CTRL: begin
          rdata <= {ctrl.converter_enable, ctrl.track_mode,
            ctrl.conv_done_flag, busy, ctrl.start_mode,
            ctrl.window_match_flag, ctrl.left_justify};
        end
        acs_pkg::OFS_CONFIG: rdata <= config_reg;
        acs_pkg::OFS_RES_HIGH: rdata <= just_word[15:8];
        acs_pkg::OFS_RES_LOW: rdata <= just_word[7:0];
        acs_pkg::OFS_IRQ_STATUS: rdata <= {6'h00, status};
        acs_pkg::OFS_IRQ_ENABLE: rdata <= {6'h00, irq_en};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_mode_timer3: assert property (@(posedge mclk) disable iff (reset)
    (ctrl.start_mode == acs_pkg::SM_TIMER3) && timer3_ovf && !busy
    && ctrl.converter_enable && gap_cnt == 12'h000 |=> busy)
    else $error("timer 3 overflow did not start");

  chk_sw_start: assert property (@(posedge mclk) disable iff (reset)
    (ctrl.start_mode == acs_pkg::SM_SOFTWARE) && sw_start && !busy
    && ctrl.converter_enable && gap_cnt == 12'h000 |=> busy)
    else $error("software start was lost");

  chk_zero_write: assert property (@(posedge mclk) disable iff (reset)
    (ctrl.start_mode == acs_pkg::SM_SOFTWARE) && !busy
    && !(ctrl_wr && wctrl.conv_busy) |=> !busy)
    else $error("conversion began without a start");

  chk_done_fall: assert property (@(posedge mclk) disable iff (reset)
    $fell(busy) && ctrl.converter_enable |-> ctrl.conv_done_flag
    && status[acs_pkg::STAT_DONE_BIT])
    else $error("done flag missing after busy fell");

  chk_irq_raise: assert property (@(posedge mclk) disable iff (reset)
    conv_end && irq_en[acs_pkg::STAT_DONE_BIT] |=> irq)
    else $error("enabled completion gave no interrupt");

  chk_left_just: assert property (@(posedge mclk) disable iff (reset)
    ctrl.left_justify |-> just_word[5:0] == 6'h00
    && just_word[15:6] == result)
    else $error("left justified result misplaced");

  chk_cont_track: assert property (@(posedge mclk) disable iff (reset)
    state == acs_pkg::ST_IDLE && !ctrl.track_mode
    && ctrl.converter_enable && !chip_standby |-> track_en)
    else $error("idle input not tracked");

  chk_track_len: assert property (@(posedge mclk) disable iff (reset)
    state == acs_pkg::ST_TRACK && next_state == acs_pkg::ST_CONV
    |-> track_cnt == 2'h2 && sar_tick)
    else $error("tracking period not three clocks");

  chk_lp_edge: assert property (@(posedge mclk) disable iff (reset)
    lp_ext && accept |=> state == acs_pkg::ST_CONV)
    else $error("pin edge did not convert at once");

  chk_shutdown: assert property (@(posedge mclk) disable iff (reset)
    !ctrl.converter_enable |-> !track_en ##1 state == acs_pkg::ST_IDLE)
    else $error("disabled converter still active");

  chk_rate_gap: assert property (@(posedge mclk) disable iff (reset)
    accept |=> gap_cnt == acs_pkg::GAP_LOAD ##1 !accept)
    else $error("throughput gate not armed");

  chk_standby: assert property (@(posedge mclk) disable iff (reset)
    chip_standby |-> !track_en)
    else $error("tracking during standby");

  chk_busy_ignore: assert property (@(posedge mclk) disable iff (reset)
    start_evt && state == acs_pkg::ST_CONV && !conv_end
    && ctrl.converter_enable |=> state == acs_pkg::ST_CONV
    && status[acs_pkg::STAT_OVERRUN_BIT])
    else $error("start during conversion not ignored");

endmodule : acs_sequencer

//--- acs_far_model.sv
// Far side model: timer overflows, start pin and analog sample
`timescale 1ns/100ps
module acs_far_model (
  // Clock
  input wire logic mclk,
  // Converter state
  input wire logic hold_convert,
  // Start sources and analog sample
  output logic timer3_ovf,
  output logic timer2_ovf,
  output logic ext_conv_start,
  output logic [acs_pkg::RES_W-1:0] ana_result
);
  logic [acs_pkg::RES_W-1:0] sample_val;

  initial begin
    timer3_ovf = 1'b0;
    timer2_ovf = 1'b0;
    ext_conv_start = 1'b0;
    ana_result = 10'h000;
    sample_val = 10'h000;
  end

  // Sample steady only while converting, scrambled otherwise
  always @(posedge mclk) begin
    ana_result <= hold_convert ? sample_val : ~ana_result;
  end

  task automatic pulse(input logic t3);
    @(posedge mclk);
    if (t3) timer3_ovf <= 1'b1;
    else timer2_ovf <= 1'b1;
    @(posedge mclk);
    timer3_ovf <= 1'b0;
    timer2_ovf <= 1'b0;
  endtask : pulse

  task automatic set_pin(input logic v);
    @(posedge mclk);
    ext_conv_start <= v;
  endtask : set_pin
endmodule : acs_far_model

//--- acs_sequencer_tb_top.sv
// Self-checking testbench of the conversion sequencer
`timescale 1ns/100ps
module acs_sequencer_tb_top;
  logic mclk;
  logic reset;
  acs_pkg::acs_req_t req;
  logic [7:0] rdata;
  logic timer3_ovf;
  logic timer2_ovf;
  logic ext_conv_start;
  logic chip_standby;
  logic [acs_pkg::RES_W-1:0] ana_result;
  logic analog_power;
  logic track_en;
  logic hold_convert;
  logic irq;
  logic [7:0] d;
  logic [7:0] ctl;
  logic [9:0] smp;
  int n;
  int n_mismatch;
  int n_tests;

  always #2 mclk = ~mclk;

  acs_sequencer acs_sequencer_i (.mclk(mclk), .reset(reset), .req(req),
    .rdata(rdata), .timer3_ovf(timer3_ovf), .timer2_ovf(timer2_ovf),
    .ext_conv_start(ext_conv_start), .chip_standby(chip_standby),
    .ana_result(ana_result), .analog_power(analog_power),
    .track_en(track_en), .hold_convert(hold_convert), .irq(irq));

  acs_far_model acs_far_model_i (.mclk(mclk), .hold_convert(hold_convert),
    .timer3_ovf(timer3_ovf), .timer2_ovf(timer2_ovf),
    .ext_conv_start(ext_conv_start), .ana_result(ana_result));

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [9:0] seen,
                     input logic [9:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    req <= acs_pkg::acs_req_t'{a, v, 1'b1, 1'b0};
    @(posedge mclk);
    req <= '0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    req <= acs_pkg::acs_req_t'{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    req <= '0;
    #1 v = rdata;
  endtask : rd

  task automatic to_conv(output int c);
    c = 0;
    while (hold_convert !== 1'b1 && c < 300) begin
      @(posedge mclk);
      #1 c++;
    end
  endtask : to_conv

  // Poll the done flag under a bounded count
  task automatic wait_done;
    int k;
    k = 0;
    d = 8'h00;
    while (d[5] !== 1'b1 && k < 200) begin
      rd(4'h0, d);
      k++;
    end
  endtask : wait_done

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    print_verdict;
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    req = '0;
    chip_standby = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    rd(acs_pkg::OFS_CTRL, d);
    chk("ctrl_reset", d, 8'h00);
    chk("power_off", analog_power, 1'b0);
    rd(acs_pkg::OFS_CONFIG, d);
    chk("config_reset", d, 8'hF8);
    rd(4'hF, d);
    chk("unmapped", d, 8'h00);
    wr(acs_pkg::OFS_CONFIG, 8'h18);
    rd(acs_pkg::OFS_CONFIG, d);
    chk("divider", d, 8'h18);
    wr(acs_pkg::OFS_IRQ_ENABLE, 8'h01);
    smp = 10'h2B5;
    acs_far_model_i.sample_val = smp;
    wr(acs_pkg::OFS_CTRL, 8'h80);
    chk("power_on", analog_power, 1'b1);
    chk("track_idle", track_en, 1'b1);
    @(posedge mclk);
    chip_standby <= 1'b1;
    #1 chk("standby", track_en, 1'b0);
    @(posedge mclk);
    chip_standby <= 1'b0;
    wr(acs_pkg::OFS_CTRL, 8'h80);
    repeat (4) @(posedge mclk);
    chk("busy_zero", hold_convert, 1'b0);
    wr(acs_pkg::OFS_CTRL, 8'h90);
    chk("converting", hold_convert, 1'b1);
    chk("no_track", track_en, 1'b0);
    wr(acs_pkg::OFS_CTRL, 8'h90);
    rd(acs_pkg::OFS_CTRL, d);
    chk("busy_read", d[4], 1'b1);
    wait_done;
    chk("ctrl_done", d, 8'hA0);
    chk("irq_set", irq, 1'b1);
    rd(acs_pkg::OFS_RES_HIGH, d);
    chk("right_high", d, {6'h00, smp[9:8]});
    rd(acs_pkg::OFS_RES_LOW, d);
    chk("right_low", d, smp[7:0]);
    wr(acs_pkg::OFS_CTRL, 8'hA1);
    rd(acs_pkg::OFS_RES_HIGH, d);
    chk("left_high", d, smp[9:2]);
    rd(acs_pkg::OFS_RES_LOW, d);
    chk("left_low", d, {smp[1:0], 6'h00});
    rd(acs_pkg::OFS_IRQ_STATUS, d);
    chk("overrun", d, 8'h03);
    wr(acs_pkg::OFS_IRQ_ENABLE, 8'h00);
    chk("irq_masked", irq, 1'b0);
    wr(acs_pkg::OFS_IRQ_ENABLE, 8'h01);
    chk("irq_unmasked", irq, 1'b1);
    wr(acs_pkg::OFS_IRQ_CLEAR, 8'h03);
    chk("irq_cleared", irq, 1'b0);
    wr(acs_pkg::OFS_CTRL, 8'h90);
    repeat (8) @(posedge mclk);
    chk("rate_gate", hold_convert, 1'b0);
    rd(acs_pkg::OFS_IRQ_STATUS, d);
    chk("gate_overrun", d, 8'h02);
    for (int m = 1; m < 4; m++) begin
      repeat (2600) @(posedge mclk);
      smp = 10'h155 + 10'(m);
      acs_far_model_i.sample_val = smp;
      ctl = 8'h80 | 8'(m << 2);
      wr(acs_pkg::OFS_CTRL, ctl);
      wr(acs_pkg::OFS_CTRL, ctl | 8'h10);
      acs_far_model_i.pulse(m != 1);
      repeat (8) @(posedge mclk);
      chk("wrong_source", hold_convert, 1'b0);
      if (m == 2) acs_far_model_i.set_pin(1'b1);
      else acs_far_model_i.pulse(m == 1);
      to_conv(n);
      chk("source_start", n < 12, 1'b1);
      wait_done;
      chk("mode_done", d, ctl | 8'h20);
      acs_far_model_i.set_pin(1'b0);
      rd(acs_pkg::OFS_RES_LOW, d);
      chk("mode_result", d, smp[7:0]);
    end
    repeat (2600) @(posedge mclk);
    wr(acs_pkg::OFS_CTRL, 8'hC0);
    wr(acs_pkg::OFS_CTRL, 8'hD0);
    chk("track_phase", {track_en, hold_convert}, 2'b10);
    to_conv(n);
    chk("track_len", n >= 8 && n <= 13, 1'b1);
    wait_done;
    repeat (2600) @(posedge mclk);
    wr(acs_pkg::OFS_CTRL, 8'hC8);
    repeat (2) @(posedge mclk);
    chk("pin_low_track", track_en, 1'b1);
    acs_far_model_i.set_pin(1'b1);
    to_conv(n);
    chk("pin_latency", n >= 3 && n <= 8, 1'b1);
    chk("pin_hold", track_en, 1'b0);
    wait_done;
    acs_far_model_i.set_pin(1'b0);
    repeat (2600) @(posedge mclk);
    wr(acs_pkg::OFS_CTRL, 8'h80);
    wr(acs_pkg::OFS_CTRL, 8'h90);
    chk("abort_busy", hold_convert, 1'b1);
    wr(acs_pkg::OFS_CTRL, 8'h00);
    @(posedge mclk);
    #1 chk("abort", {analog_power, hold_convert}, 2'b00);
    repeat (60) @(posedge mclk);
    rd(acs_pkg::OFS_CTRL, d);
    chk("abort_no_done", d, 8'h00);
    print_verdict;
  end
endmodule : acs_sequencer_tb_top
